// File: idig_pkg.sv
// Purpose: Shared constants for the digital I/O expansion card glue logic.
// Assumes: Byte-wide register bus, ten-bit host I/O address.
// Notes: Card-level registers sit after the per-unit register groups.
package idig_pkg;
    // Block layout.
    localparam int UNITS = 5;
    localparam int REGS_PER_UNIT = 4;
    localparam int LINES_PER_UNIT = 24;
    localparam logic [4:0] BLOCK_BYTES = 5'h18;
    localparam int ADDR_W = 10;
    localparam int BASE_LSB = 5;

    // Per-unit register offsets inside a four-address group.
    localparam logic [1:0] UOFF_PORT_A = 2'h0;
    localparam logic [1:0] UOFF_PORT_B = 2'h1;
    localparam logic [1:0] UOFF_PORT_C = 2'h2;
    localparam logic [1:0] UOFF_CTRL = 2'h3;

    // Card-level register offsets inside the block.
    localparam logic [4:0] OFF_BUF_CTRL = 5'h14;
    localparam logic [4:0] OFF_IRQ_STAT = 5'h15;
    localparam logic [4:0] OFF_IRQ_MASK = 5'h16;
    localparam logic [4:0] OFF_IRQ_LIVE = 5'h17;

    // Control byte fields of a port unit.
    localparam int CTRL_MODE_SET_BIT = 7;
    localparam int CTRL_A_IN_BIT = 4;
    localparam int CTRL_CU_IN_BIT = 3;
    localparam int CTRL_B_IN_BIT = 1;
    localparam int CTRL_CL_IN_BIT = 0;
    localparam int CTRL_BSR_LSB = 1;
    localparam int CTRL_BSR_VAL_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h9B;

    // Interrupt lines within port C, and card control fields.
    localparam int IRQ_IN_BIT = 3;
    localparam int IRQ_GATE_BIT = 7;
    localparam int BUF_EN_BIT = 0;
    localparam logic BUF_EN_RESET = 1'b0;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [15:0] VALID_IRQ_LEVELS = 16'hDCFC;
endpackage : idig_pkg

// File: idig_unit_if.sv
// Purpose: Register access path from the card decoder to one port unit.
// Assumes: Single clock; wr is a one-cycle pulse.
// Notes: rdat is combinational from the unit.
`timescale 1ns/1ps
interface idig_unit_if;
    logic wr;
    logic [1:0] addr;
    logic [7:0] wdat;
    logic [7:0] rdat;

    modport card
    (
        output wr,
        output addr,
        output wdat,
        input rdat
    );

    modport unit
    (
        input wr,
        input addr,
        input wdat,
        output rdat
    );
endinterface : idig_unit_if

// File: idig_port_unit.sv
// Purpose: One parallel port unit with ports A, B and C and a control byte.
// Assumes: Simple input/latched-output mode only.
// Notes: Control bit 7 set loads the direction byte; clear sets/resets a C bit.
`timescale 1ns/1ps
module idig_port_unit
(
    input wire logic clock,
    input wire logic srst,
    idig_unit_if.unit bus,
    input wire logic buf_en,
    input wire logic [23:0] line_in,
    output logic [23:0] latch_out,
    output logic [23:0] dir_out
);
    logic [7:0] ctrl_r;
    logic [7:0] a_r;
    logic [7:0] b_r;
    logic [7:0] c_r;
    logic a_out;
    logic b_out;
    logic cu_out;
    logic cl_out;
    logic mode_wr;
    logic bsr_wr;
    logic [2:0] bsr_bit;
    logic [23:0] seen_in;
    logic [23:0] port_val;

    assign a_out = ~ctrl_r[idig_pkg::CTRL_A_IN_BIT];
    assign b_out = ~ctrl_r[idig_pkg::CTRL_B_IN_BIT];
    assign cu_out = ~ctrl_r[idig_pkg::CTRL_CU_IN_BIT];
    assign cl_out = ~ctrl_r[idig_pkg::CTRL_CL_IN_BIT];
    assign dir_out = {{4{cu_out}}, {4{cl_out}}, {8{b_out}}, {8{a_out}}};
    assign latch_out = {c_r, b_r, a_r};

    assign mode_wr = bus.wr && bus.addr == idig_pkg::UOFF_CTRL
        && bus.wdat[idig_pkg::CTRL_MODE_SET_BIT];
    assign bsr_wr = bus.wr && bus.addr == idig_pkg::UOFF_CTRL
        && !bus.wdat[idig_pkg::CTRL_MODE_SET_BIT];
    assign bsr_bit = bus.wdat[idig_pkg::CTRL_BSR_LSB +: 3];

    // Input bits read the line when the buffers pass it, else the pull-down.
    assign seen_in = buf_en ? line_in : 24'h000000;
    assign port_val = (latch_out & dir_out) | (seen_in & ~dir_out);

    assign bus.rdat = bus.addr == idig_pkg::UOFF_PORT_A ? port_val[7:0]
        : bus.addr == idig_pkg::UOFF_PORT_B ? port_val[15:8]
        : bus.addr == idig_pkg::UOFF_PORT_C ? port_val[23:16]
        : ctrl_r;

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            ctrl_r <= idig_pkg::CTRL_RESET;
        end
        else if (mode_wr)
        begin
            ctrl_r <= bus.wdat;
        end
    end

    // A mode load clears all output latches, as a fresh setup should.
    always_ff @(posedge clock)
    begin
        if (srst || mode_wr)
        begin
            a_r <= 8'h00;
            b_r <= 8'h00;
            c_r <= 8'h00;
        end
        else if (bus.wr)
        begin
            if (bus.addr == idig_pkg::UOFF_PORT_A)
            begin
                a_r <= bus.wdat;
            end
            if (bus.addr == idig_pkg::UOFF_PORT_B)
            begin
                b_r <= bus.wdat;
            end
            if (bus.addr == idig_pkg::UOFF_PORT_C)
            begin
                c_r <= bus.wdat;
            end
            if (bsr_wr)
            begin
                c_r[bsr_bit] <= bus.wdat[idig_pkg::CTRL_BSR_VAL_BIT];
            end
        end
    end
endmodule : idig_port_unit

// File: idig_card.sv
// Purpose: Host glue of the digital I/O card: decode, buffers, interrupts.
// Assumes: Classic Wishbone slave, 8-bit data, one 20 MHz clock.
// Notes: Jumpers and switches arrive as static synchronous inputs.
// Functional notes
// - Answer only the 24 consecutive bytes of the card's block; the code acks any address and reads 0x00 outside it.
// - Compare address bits 9 to 5 with the switch-set base.
// - Provide the external lines through the port units, ports A, B, C.
// - Each eight-bit port is software-set as inputs or latched outputs.
// - Port C may split: one nibble input, the other latched output.
// - Line buffer direction follows each port's programmed direction.
// - Always-on buffer setting keeps all buffers enabled regardless.
// - Soft buffer setting lets software enable or tristate the buffers.
// - Port interrupt enabled by jumper alone or jumper plus input level.
// - All port interrupts are ORed into one host request; the code ORs only latched status bits whose mask bit is set.
// - Route the request to one IRQ among 2-7, 10-12, 14, 15.
// - Two lines per unit serve interrupt: input and enable qualifier.
// - Interrupt input is port C bit 3, active high.
// - Gated jumper passes only while C7 is low; no jumper blocks.
// - Address bits 4 to 0 pick the register within the block.
// - Switches are negative-true: an off switch means a one.
`timescale 1ns/1ps
module idig_card
#(
    parameter int UNITS = idig_pkg::UNITS
)
(
    input wire logic clock,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic wb_sel_i,
    input wire logic [7:0] wb_dat_i,
    output logic [7:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [4:0] base_switch_on,
    input wire logic buffer_always_on_setting,
    input wire logic [UNITS-1:0] irq_always_enable_jumper,
    input wire logic [UNITS-1:0] irq_input_gated_jumper,
    input wire logic [3:0] irq_level_sel,
    input wire logic [UNITS*24-1:0] line_in,
    output logic [UNITS*24-1:0] line_out,
    output logic [UNITS*24-1:0] line_oe_n,
    output logic [15:0] host_irq
);
    localparam int NL = UNITS * idig_pkg::LINES_PER_UNIT;

    // Five units plus the card registers fill the block exactly.
    if (UNITS < 1 || UNITS > idig_pkg::UNITS)
    begin : g_bad_units
        $error("UNITS must lie between 1 and 5");
    end

    logic ack_r;
    logic [7:0] dat_r;
    logic buf_soft_en_r;
    logic [UNITS-1:0] stat_r;
    logic [UNITS-1:0] stat_nxt;
    logic [UNITS-1:0] mask_r;
    logic [UNITS-1:0] irq_prev_r;
    logic [NL-1:0] line_out_r;
    logic [NL-1:0] line_oe_n_r;
    logic [15:0] host_irq_r;

    logic req;
    logic fire;
    logic [4:0] base_value;
    logic hit_base;
    logic [4:0] reg_off;
    logic in_block;
    logic [2:0] unit_sel;
    logic is_unit;
    logic wr_fire;
    logic rd_fire;
    logic card_wr;
    logic buf_en;
    logic [NL-1:0] latch_all;
    logic [NL-1:0] dir_all;
    logic [7:0] unit_rdat [0:7];
    logic [7:0] card_rdat;
    logic [7:0] rdat;
    logic [UNITS-1:0] unit_irq;
    logic [UNITS-1:0] irq_rise;
    logic stat_clr;
    logic irq_any;
    logic [15:0] irq_route;
    logic take;
    logic sel_buf_ctrl;
    logic sel_irq_stat;
    logic sel_irq_mask;
    logic sel_irq_live;
    logic ack_nxt;
    logic [7:0] dat_nxt;
    logic buf_soft_en_nxt;
    logic [UNITS-1:0] mask_nxt;
    logic [15:0] host_irq_nxt;
    logic [NL-1:0] line_out_nxt;
    logic [NL-1:0] line_oe_n_nxt;

    // Bus handshake: ack rises one cycle after the request and lasts one.
    assign req = wb_cyc_i && wb_stb_i;
    assign fire = req && ack_r;

    // Block decode.
    assign base_value = ~base_switch_on;
    assign hit_base = wb_adr_i[9:idig_pkg::BASE_LSB] == base_value;
    assign reg_off = wb_adr_i[idig_pkg::BASE_LSB-1:0];
    assign in_block = hit_base && reg_off < idig_pkg::BLOCK_BYTES;
    assign unit_sel = reg_off[4:2];
    assign is_unit = in_block && unit_sel < 3'(UNITS);
    assign wr_fire = fire && wb_we_i && wb_sel_i && in_block;
    assign rd_fire = fire && !wb_we_i && in_block;
    assign card_wr = wr_fire && !is_unit;

    // Buffers pass when the jumper says always-on or software enabled them.
    assign buf_en = buffer_always_on_setting || buf_soft_en_r;

    for (genvar u = 0; u < 8; u++)
    begin : g_unit
        if (u < UNITS)
        begin : g_real
            idig_unit_if bus_if ();

            assign bus_if.wr = wr_fire && is_unit && unit_sel == 3'(u);
            assign bus_if.addr = reg_off[1:0];
            assign bus_if.wdat = wb_dat_i;
            assign unit_rdat[u] = bus_if.rdat;

            idig_port_unit u_unit
            (
                .clock(clock),
                .srst(srst),
                .bus(bus_if),
                .buf_en(buf_en),
                .line_in(line_in[u*24 +: 24]),
                .latch_out(latch_all[u*24 +: 24]),
                .dir_out(dir_all[u*24 +: 24])
            );

            // Port C bit 3 is the request, bit 7 low is the gate.
            assign unit_irq[u] = line_in[u*24 + 16 + idig_pkg::IRQ_IN_BIT]
                && (irq_always_enable_jumper[u]
                || (irq_input_gated_jumper[u]
                && !line_in[u*24 + 16 + idig_pkg::IRQ_GATE_BIT]));
        end
        else
        begin : g_none
            assign unit_rdat[u] = 8'h00;
        end
    end

    // Card register selects; only used once the unit range is excluded.
    assign sel_buf_ctrl = reg_off == idig_pkg::OFF_BUF_CTRL;
    assign sel_irq_stat = reg_off == idig_pkg::OFF_IRQ_STAT;
    assign sel_irq_mask = reg_off == idig_pkg::OFF_IRQ_MASK;
    assign sel_irq_live = reg_off == idig_pkg::OFF_IRQ_LIVE;

    // Card-level register read decode.
    assign card_rdat = sel_buf_ctrl ? {7'h00, buf_soft_en_r}
        : sel_irq_stat ? 8'(stat_r)
        : sel_irq_mask ? 8'(mask_r)
        : sel_irq_live ? 8'(unit_irq)
        : 8'h00;
    assign rdat = !in_block ? 8'h00
        : is_unit ? unit_rdat[unit_sel]
        : card_rdat;

    // Status: a rising qualified request sets; a read clears; set wins.
    assign irq_rise = unit_irq & ~irq_prev_r;
    assign stat_clr = rd_fire && sel_irq_stat;
    assign stat_nxt = (stat_clr ? '0 : stat_r) | irq_rise;
    assign irq_any = |(stat_r & mask_r);
    assign irq_route = (16'h0001 << irq_level_sel)
        & idig_pkg::VALID_IRQ_LEVELS;

    // A request is taken on the edge where ack is still low.
    assign take = req && !ack_r;
    assign ack_nxt = take;
    assign dat_nxt = take ? rdat : dat_r;
    assign buf_soft_en_nxt = card_wr && sel_buf_ctrl
        ? wb_dat_i[idig_pkg::BUF_EN_BIT] : buf_soft_en_r;
    assign mask_nxt = card_wr && sel_irq_mask ? wb_dat_i[UNITS-1:0] : mask_r;
    assign host_irq_nxt = irq_any ? irq_route : 16'h0000;
    // Buffers drive only output-programmed lines, and only when enabled.
    assign line_out_nxt = latch_all;
    assign line_oe_n_nxt = ~(dir_all & {NL{buf_en}});

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            ack_r <= 1'b0;
        end
        else
        begin
            ack_r <= ack_nxt;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            dat_r <= 8'h00;
        end
        else
        begin
            dat_r <= dat_nxt;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            buf_soft_en_r <= idig_pkg::BUF_EN_RESET;
        end
        else
        begin
            buf_soft_en_r <= buf_soft_en_nxt;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            mask_r <= idig_pkg::MASK_RESET[UNITS-1:0];
        end
        else
        begin
            mask_r <= mask_nxt;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            stat_r <= '0;
        end
        else
        begin
            stat_r <= stat_nxt;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            irq_prev_r <= '0;
        end
        else
        begin
            irq_prev_r <= unit_irq;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            host_irq_r <= 16'h0000;
        end
        else
        begin
            host_irq_r <= host_irq_nxt;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            line_out_r <= '0;
        end
        else
        begin
            line_out_r <= line_out_nxt;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            line_oe_n_r <= '1;
        end
        else
        begin
            line_oe_n_r <= line_oe_n_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign line_out = line_out_r;
    assign line_oe_n = line_oe_n_r;
    assign host_irq = host_irq_r;
endmodule : idig_card

// File: idig_asserts.sv
// Purpose: Bus and interrupt relations of the card glue at its pins.
// Assumes: One clock, srst synchronous and active high.
// Notes: Bound to idig_card below the module.
`timescale 1ns/1ps
module idig_asserts
#(
    parameter int UNITS = 5
)
(
    input wire logic clock,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [7:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [4:0] base_switch_on,
    input wire logic [3:0] irq_level_sel,
    input wire logic [UNITS*24-1:0] line_oe_n,
    input wire logic [15:0] host_irq
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);
    AST_ACK_LAT: assert property (
        $rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
        else $error("ack not one cycle after request");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_NOREQ: assert property (
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    AST_OUT_ZERO: assert property (wb_ack_o && !wb_we_i &&
        wb_adr_i[4:0] >= 5'h18 |-> wb_dat_o == 8'h00)
        else $error("offset past block read nonzero");
    AST_BASE_MISS: assert property (wb_ack_o && !wb_we_i &&
        wb_adr_i[9:5] != ~base_switch_on |-> wb_dat_o == 8'h00)
        else $error("foreign base read nonzero");
    AST_IRQ_SEL: assert property (|host_irq |->
        host_irq == (16'h0001 << $past(irq_level_sel)))
        else $error("irq on wrong level");
    AST_IRQ_BAD: assert property (
        !idig_pkg::VALID_IRQ_LEVELS[irq_level_sel] |=> host_irq == 16'h0000)
        else $error("irq on invalid level");
    AST_OE_RST: assert property ($fell(srst) |-> &line_oe_n)
        else $error("lines driven after reset");
endmodule : idig_asserts
bind idig_card idig_asserts #(.UNITS(UNITS)) chk_u (.clock(clock),
    .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .base_switch_on(base_switch_on),
    .irq_level_sel(irq_level_sel), .line_oe_n(line_oe_n),
    .host_irq(host_irq));

// File: idig_line_model.sv
// Purpose: Field wiring on the external lines of the card.
// Assumes: A driven line carries the card's value.
// Notes: A released line takes the value that the field drives.
`timescale 1ns/1ps
module idig_line_model
#(
    parameter int N = 120
)
(
    input wire logic [N-1:0] line_out,
    input wire logic [N-1:0] line_oe_n,
    input wire logic [N-1:0] ext_drive,
    output logic [N-1:0] line_in
);
    assign line_in = (~line_oe_n & line_out) | (line_oe_n & ext_drive);
endmodule : idig_line_model

// File: tb_top.sv
// Purpose: Self-checking bench of the card glue.
// Assumes: Host bus master at 20 MHz, card base 0x2C0.
// Notes: Reads leave notes in a queue that a monitor checks.
`timescale 1ns/1ps
module tb_top;
    localparam logic [4:0] BASE = 5'h16;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, sel = 1'b0, aon = 1'b1;
    logic [9:0] adr = 10'h000;
    logic [7:0] dat = 8'h00;
    logic [4:0] ij = 5'h00, gj = 5'h00, bsel = BASE;
    logic [3:0] lvl = 4'h5;
    logic [119:0] ext, lin, lout, oen;
    logic [7:0] rdat;
    logic [7:0] exp_rd;
    logic ack;
    logic [15:0] irq;
    logic [7:0] exp_q[$];
    int fails = 0, n_compared = 0;
    logic [31:0] rs = 32'h000073BF;
    initial
    begin
        forever #25 clock = ~clock;
    end
    idig_card dut_u (.clock(clock), .srst(srst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .base_switch_on(~BASE), .buffer_always_on_setting(aon),
        .irq_always_enable_jumper(ij), .irq_input_gated_jumper(gj),
        .irq_level_sel(lvl), .line_in(lin), .line_out(lout),
        .line_oe_n(oen), .host_irq(irq));
    idig_line_model line_u (.line_out(lout), .line_oe_n(oen),
        .ext_drive(ext), .line_in(lin));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs
    task automatic chk(input string n, input logic [23:0] s, e);
        n_compared++;
        if (s !== e)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [4:0] o,
        input logic [7:0] v);
        @(posedge clock);
        {cyc, stb, we, sel} <= {2'b11, w, 1'b1};
        adr <= {bsel, o};
        dat <= v;
        do @(posedge clock); while (ack !== 1'b1);
        {cyc, stb} <= 2'b00;
    endtask : bus
    task automatic rd(input logic [4:0] o, input logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b0, o, 8'h00);
    endtask : rd
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim
    // Each read answer is matched against the oldest note.
    always @(posedge clock)
    begin
        if (ack === 1'b1 && we === 1'b0)
        begin
            exp_rd = exp_q.pop_front();
            chk("read data", {16'h0, rdat}, {16'h0, exp_rd});
        end
    end
    initial
    begin
        repeat (4000) @(posedge clock);
        fails++;
        end_sim;
    end
    initial
    begin
        ext <= {rs, rs, rs, rs[23:0]};
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        rd(5'h03, 8'h9B);
        rd(5'h14, 8'h00);
        rd(5'h18, 8'h00);
        bsel = 5'h00;
        rd(5'h03, 8'h00);
        bsel = BASE;
        for (int u = 0; u < 5; u++)
        begin
            rs = xs(rs);
            bus(1'b1, 5'(4 * u + 3), 8'h80);
            bus(1'b1, 5'(4 * u), rs[7:0]);
            rd(5'(4 * u), rs[7:0]);
            chk("line out", lout[u * 24 +: 24], {16'h0, rs[7:0]});
            chk("drive", oen[u * 24 +: 24], 24'h000000);
        end
        aon <= 1'b0;
        repeat (2) @(posedge clock);
        chk("soft off", oen[23:0], 24'hFFFFFF);
        bus(1'b1, 5'h14, 8'h01);
        rd(5'h14, 8'h01);
        chk("soft on", oen[23:0], 24'h000000);
        bus(1'b1, 5'h14, 8'h00);
        repeat (2) @(posedge clock);
        chk("soft off", oen[23:0], 24'hFFFFFF);
        aon <= 1'b1;
        repeat (2) @(posedge clock);
        chk("always on", oen[23:0], 24'h000000);
        bus(1'b1, 5'h03, 8'h81);
        bus(1'b1, 5'h02, 8'hA5);
        rd(5'h02, {4'hA, ext[19:16]});
        chk("split", oen[23:0], 24'h0F0000);
        bus(1'b1, 5'h03, 8'h0D);
        rd(5'h02, {4'hE, ext[19:16]});
        bus(1'b1, 5'h07, 8'h9B);
        ext[43] <= 1'b0;
        ij <= 5'h02;
        repeat (2) @(posedge clock);
        ext[43] <= 1'b1;
        repeat (4) @(posedge clock);
        chk("masked irq", {8'h0, irq}, 24'h0);
        bus(1'b1, 5'h16, 8'h02);
        repeat (3) @(posedge clock);
        chk("irq", {8'h0, irq}, 24'h000020);
        rd(5'h15, 8'h02);
        repeat (3) @(posedge clock);
        chk("irq cleared", {8'h0, irq}, 24'h0);
        rd(5'h17, 8'h02);
        {ij, gj} <= {5'h00, 5'h02};
        ext[47] <= 1'b1;
        rd(5'h17, 8'h00);
        ext[47] <= 1'b0;
        rd(5'h17, 8'h02);
        gj <= 5'h00;
        rd(5'h17, 8'h00);
        chk("gated irq", {8'h0, irq}, 24'h000020);
        lvl <= 4'h8;
        repeat (3) @(posedge clock);
        chk("bad level", {8'h0, irq}, 24'h0);
        end_sim;
    end
endmodule : tb_top
